// ---- rtl/ldorc_control.sv ----
// regulator control register, dropout indicator and dropout interrupt request
// Notes on behaviour
// - control register sits at address 0xC9 on page 0x00.
// - bit 7 is read/write regulator off; 1 turns regulator off.
// - regulator-off bit resets to 0 so regulator starts on.
// - bit 4 selects output level, 0 for 2.1V, 1 for 2.6V, resets 1.
// - bit 0 reads dropout indicator, 1 in or near dropout, resets 0.
// - only hardware clears dropout indicator; software writes cannot touch it.
// - dropout with interrupt enable set raises the interrupt request.
// - no pending flag; request follows the condition directly.
// - bit 6 reads 0; software must write 0 there.
// - bits 5 and 3:1 read 0 and ignore writes.
`timescale 1ns/1ps
module ldorc_control
  import ldorc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire ldorc_sfr_req_type sfr_req,
  input  wire logic              dropout_raw,
  input  wire logic              dropout_irq_enable,
  output logic [7:0]             sfr_rdata,
  output logic                   regulator_off,
  output logic                   output_level_select,
  output logic                   dropout_irq
);
  logic [LDORC_SYNC_STAGES-1:0] sync;
  logic                         dropout;
  logic                         next_dropout;
  logic                         next_irq;
  logic                         sel;
  logic                         wr_hit;
  logic                         rd_hit;
  logic [7:0]                   ctrl_image;
  logic [7:0]                   next_rdata;

  assign sel    = (sfr_req.addr == LDORC_ADDR_CONTROL) && (sfr_req.page == LDORC_PAGE_CONTROL);
  assign wr_hit = sel && sfr_req.wr;
  assign rd_hit = sel && sfr_req.rd;

  // three-stage sync, change taken once last two stages agree
  assign next_dropout = (sync[1] == sync[2]) ? sync[2] : dropout;
  // straight and of level and enable
  assign next_irq = next_dropout & dropout_irq_enable;

  // register image, one field per bit position
  for (genvar b = 0; b < 8; b++) begin : g_image
    if (b == LDORC_BIT_OFF) begin : g_off
      assign ctrl_image[b] = regulator_off;
    end else if (b == LDORC_BIT_LEVEL) begin : g_level
      assign ctrl_image[b] = output_level_select;
    end else if (b == LDORC_BIT_DROPOUT) begin : g_dropout
      assign ctrl_image[b] = dropout;
    end else begin : g_zero
      // must-be-zero and unused bits read zero
      assign ctrl_image[b] = 1'b0;
    end
  end

  // read data stands one cycle, zero when not addressed
  assign next_rdata = rd_hit ? ctrl_image : 8'h00;

  // three stages cost four cycles of latency but give the analog edge time to settle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync <= '0;
    end else begin
      sync <= {sync[LDORC_SYNC_STAGES-2:0], dropout_raw};
    end
  end

  // indicator follows hardware only, no write path
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dropout <= 1'b0;
    end else begin
      dropout <= next_dropout;
    end
  end

  // writable bits; other bits of wdata dropped
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      regulator_off       <= LDORC_RESET_OFF;
      output_level_select <= LDORC_RESET_LEVEL;
    end else if (sel && sfr_req.wr) begin
      regulator_off       <= sfr_req.wdata[LDORC_BIT_OFF];
      output_level_select <= sfr_req.wdata[LDORC_BIT_LEVEL];
    end
  end

  // request registered, no latch beyond one flop
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dropout_irq <= 1'b0;
      sfr_rdata   <= 8'h00;
    end else begin
      dropout_irq <= next_irq;
      sfr_rdata   <= next_rdata;
    end
  end

  property p_write_off;
    @(posedge clk_sys) disable iff (!rst_n)
      (sel && sfr_req.wr) |=> (regulator_off == $past(sfr_req.wdata[7]));
  endproperty
  a_write_off: assert property (p_write_off) else $error("regulator off not written");

  property p_write_level;
    @(posedge clk_sys) disable iff (!rst_n)
      (sel && sfr_req.wr) |=> (output_level_select == $past(sfr_req.wdata[4]));
  endproperty
  a_write_level: assert property (p_write_level) else $error("level select not written");

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      !(sel && sfr_req.wr) |=> $stable(regulator_off) && $stable(output_level_select);
  endproperty
  a_hold: assert property (p_hold) else $error("control changed without write");

  property p_reset_vals;
    @(posedge clk_sys) !rst_n |=> !regulator_off && output_level_select && !dropout_irq && !dropout &&
      (sfr_rdata == 8'h00);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

  property p_zero_bits;
    @(posedge clk_sys) disable iff (!rst_n) (sfr_rdata[6:5] == 2'h0) && (sfr_rdata[3:1] == 3'h0);
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused bit read nonzero");

  property p_read_dropout;
    @(posedge clk_sys) disable iff (!rst_n)
      (sel && sfr_req.rd) |=> (sfr_rdata[0] == $past(dropout));
  endproperty
  a_read_dropout: assert property (p_read_dropout) else $error("indicator read wrong");

  sequence s_raw_high;
    dropout_raw [*5];
  endsequence
  property p_sync_rise;
    @(posedge clk_sys) disable iff (!rst_n) s_raw_high |-> dropout;
  endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("dropout not taken after sync");

  property p_no_sw_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      (dropout && sync[2] && sync[1]) |=> dropout;
  endproperty
  a_no_sw_clear: assert property (p_no_sw_clear) else $error("indicator cleared early");

  property p_irq;
    @(posedge clk_sys) disable iff (!rst_n)
      ##1 (dropout_irq == (dropout && $past(dropout_irq_enable)));
  endproperty
  a_irq: assert property (p_irq) else $error("irq not and of dropout and enable");

  property p_irq_follow;
    @(posedge clk_sys) disable iff (!rst_n) (!dropout_irq_enable ##1 1'b1) |-> !dropout_irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq held without enable");

  // read data is zero when the register is not read
  property p_rdata_idle;
    @(posedge clk_sys) disable iff (!rst_n) !rd_hit |=> (sfr_rdata == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");

  property p_read_off;
    @(posedge clk_sys) disable iff (!rst_n)
      rd_hit |=> (sfr_rdata[LDORC_BIT_OFF] == $past(regulator_off));
  endproperty
  a_read_off: assert property (p_read_off) else $error("regulator off read wrong");

  property p_read_level;
    @(posedge clk_sys) disable iff (!rst_n)
      rd_hit |=> (sfr_rdata[LDORC_BIT_LEVEL] == $past(output_level_select));
  endproperty
  a_read_level: assert property (p_read_level) else $error("level select read wrong");

  // condition gone long enough must clear the indicator
  sequence s_raw_low;
    !dropout_raw [*5];
  endsequence
  property p_sync_fall;
    @(posedge clk_sys) disable iff (!rst_n) s_raw_low |-> !dropout;
  endproperty
  a_sync_fall: assert property (p_sync_fall) else $error("dropout not cleared after sync");

  property p_rise_synced;
    @(posedge clk_sys) disable iff (!rst_n) $rose(dropout) |-> $past(sync[1]) && $past(sync[2]);
  endproperty
  a_rise_synced: assert property (p_rise_synced) else $error("indicator rose before sync agreed");

  property p_fall_synced;
    @(posedge clk_sys) disable iff (!rst_n)
      $fell(dropout) && $past(rst_n) |-> !$past(sync[1]) && !$past(sync[2]);
  endproperty
  a_fall_synced: assert property (p_fall_synced) else $error("indicator fell before sync agreed");

  sequence s_enabled_then_dropout;
    dropout_irq_enable ##1 dropout;
  endsequence
  property p_irq_raise;
    @(posedge clk_sys) disable iff (!rst_n) s_enabled_then_dropout |-> dropout_irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("irq missing on enabled dropout");

  property p_irq_needs_enable;
    @(posedge clk_sys) disable iff (!rst_n) dropout_irq |-> $past(dropout_irq_enable);
  endproperty
  a_irq_needs_enable: assert property (p_irq_needs_enable) else $error("irq without enable");

  // no pending bit, so a dropout shorter than a poll interval is lost to software
  property p_irq_no_latch;
    @(posedge clk_sys) disable iff (!rst_n) !dropout |-> !dropout_irq;
  endproperty
  a_irq_no_latch: assert property (p_irq_no_latch) else $error("irq stands without dropout");
endmodule : ldorc_control

// ---- rtl/ldorc_pkg.sv ----
// package for the regulator control register block
package ldorc_pkg;
  localparam logic [7:0] LDORC_ADDR_CONTROL = 8'hC9;
  localparam logic [7:0] LDORC_PAGE_CONTROL = 8'h00;
  localparam int         LDORC_BIT_OFF      = 7;
  localparam int         LDORC_BIT_MUST0    = 6;
  localparam int         LDORC_BIT_LEVEL    = 4;
  localparam int         LDORC_BIT_DROPOUT  = 0;
  localparam logic [7:0] LDORC_RESET_VALUE  = 8'h10;
  localparam logic       LDORC_RESET_OFF    = 1'b0;
  localparam logic       LDORC_RESET_LEVEL  = 1'b1;
  localparam int         LDORC_SYNC_STAGES  = 3;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] page;
    logic [7:0] wdata;
  } ldorc_sfr_req_type;
endpackage : ldorc_pkg

// ---- test/ldorc_control_tb.sv ----
// self-checking bench for the regulator control register block
`timescale 1ns/1ps
module ldorc_control_tb;
  import ldorc_pkg::*;
  logic              clk_sys            = 1'b0;
  logic              rst_n              = 1'b0;
  ldorc_sfr_req_type sfr_req            = '0;
  logic              dropout_raw        = 1'b0;
  logic              dropout_irq_enable = 1'b0;
  logic [7:0]        sfr_rdata;
  logic              regulator_off;
  logic              output_level_select;
  logic              dropout_irq;
  logic [7:0]        got;
  int                n_fail   = 0;
  int                n_checks = 0;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("unexpected %0t: got %h want %h", $time, a, b); end end

  ldorc_control ldorc_control_i (
    .clk_sys            (clk_sys),
    .rst_n              (rst_n),
    .sfr_req            (sfr_req),
    .dropout_raw        (dropout_raw),
    .dropout_irq_enable (dropout_irq_enable),
    .sfr_rdata          (sfr_rdata),
    .regulator_off      (regulator_off),
    .output_level_select(output_level_select),
    .dropout_irq        (dropout_irq)
  );

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // an idle cycle follows each access so the strobe is never reassigned in one step
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
    sfr_req = '{wr: w, rd: ~w, addr: a, page: p, wdata: d};
    @(negedge clk_sys);
    got = sfr_rdata;
    sfr_req = '0;
    @(negedge clk_sys);
  endtask : acc

  task automatic t_reset;
    acc(1'b0, 8'hC9, 8'h00, 8'h00);
    `CHK(got, 8'h10)
    `CHK(regulator_off, 1'b0)
  endtask : t_reset

  task automatic t_write;
    acc(1'b1, 8'hC9, 8'h00, 8'hBF);
    `CHK(regulator_off, 1'b1)
    acc(1'b0, 8'hC9, 8'h00, 8'h00);
    `CHK(got, 8'h90)
    acc(1'b1, 8'hC9, 8'h00, 8'h00);
    acc(1'b0, 8'hC9, 8'h00, 8'h00);
    `CHK(got, 8'h00)
    `CHK(output_level_select, 1'b0)
  endtask : t_write

  task automatic t_decode;
    acc(1'b1, 8'hC8, 8'h00, 8'hFF);
    acc(1'b1, 8'hC9, 8'h01, 8'hFF);
    `CHK(regulator_off, 1'b0)
    `CHK(output_level_select, 1'b0)
    acc(1'b0, 8'hC9, 8'h01, 8'h00);
    `CHK(got, 8'h00)
  endtask : t_decode

  task automatic t_drop;
    // input quiet for a while before the enable goes up
    repeat (4) @(negedge clk_sys);
    dropout_irq_enable = 1'b1;
    @(negedge clk_sys);
    `CHK(dropout_irq, 1'b0)
    dropout_raw = 1'b1;
    repeat (3) @(negedge clk_sys);
    `CHK(dropout_irq, 1'b0)
    @(negedge clk_sys);
    `CHK(dropout_irq, 1'b1)
    acc(1'b1, 8'hC9, 8'h00, 8'h00);
    acc(1'b0, 8'hC9, 8'h00, 8'h00);
    `CHK(got, 8'h01)
    `CHK(dropout_irq, 1'b1)
    // handler drops the enable and leaves it down until the indicator clears
    dropout_irq_enable = 1'b0;
    @(negedge clk_sys);
    `CHK(dropout_irq, 1'b0)
    dropout_raw = 1'b0;
    acc(1'b0, 8'hC9, 8'h00, 8'h00);
    `CHK(got, 8'h01)
    // poll until hardware clears the indicator, then re-enable
    repeat (3) begin
      if (got[0]) acc(1'b0, 8'hC9, 8'h00, 8'h00);
    end
    `CHK(got, 8'h00)
    dropout_irq_enable = 1'b1;
    repeat (2) @(negedge clk_sys);
    `CHK(dropout_irq, 1'b0)
  endtask : t_drop

  task automatic t_rerun;
    acc(1'b1, 8'hC9, 8'h00, 8'h80);
    `CHK(regulator_off, 1'b1)
    rst_n = 1'b0;
    @(negedge clk_sys);
    `CHK(regulator_off, 1'b0)
    `CHK(output_level_select, 1'b1)
    rst_n = 1'b1;
    acc(1'b0, 8'hC9, 8'h00, 8'h00);
    `CHK(got, 8'h10)
  endtask : t_rerun

  task automatic close_out;
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  initial begin
    #5000;
    n_fail++;
    close_out();
  end

  initial begin
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    t_reset();
    t_write();
    t_decode();
    t_drop();
    t_rerun();
    close_out();
  end
endmodule : ldorc_control_tb
